/* rtl/dcs_consts.vh */
// Constants for the dual converter clock and reset supervisor.
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define DCS_CLK_HZ          25000000
`define DCS_RST_TIMEOUT_MS  180
`define DCS_RST_TIMEOUT_CYC ((`DCS_CLK_HZ / 1000) * `DCS_RST_TIMEOUT_MS)
`define DCS_GLITCH_NS       100
`define DCS_CLK_NS          40
`define DCS_GLITCH_CYC      ((`DCS_GLITCH_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
`define DCS_SS_STEPS        64
`define DCS_SS_OSC_CYC      2048
`define DCS_SS_STEP_CYC     (`DCS_SS_OSC_CYC / `DCS_SS_STEPS)
`define DCS_OSC_DIV         4
`endif

/* rtl/dcs_sync2.v */
// Two flip-flop level synchroniser.
`timescale 1ns/100ps
`default_nettype none
module dcs_sync2 #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk_i,
    input  wire rstn_i,
    input  wire d_i,
    output reg  q_o
);
    reg meta_q;
    // The first stage is read only by the second stage.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // dcs_sync2
`default_nettype wire

/* rtl/dcs_supervisor.v */
// Clocking, enable, soft-start and reset supervision for a dual converter.
`timescale 1ns/100ps
`default_nettype none
`include "dcs_consts.vh"
module dcs_supervisor #(
    parameter RST_TIMEOUT_CYC = `DCS_RST_TIMEOUT_CYC,
    parameter OSC_DIV         = `DCS_OSC_DIV
) (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       ext_ref_clk_i,
    input  wire       conv1_enable_i,
    input  wire       conv2_enable_i,
    input  wire       conv1_rate_select_i,
    input  wire       manual_reset_n_i,
    input  wire       manual_reset_n_oe_i,
    input  wire       powerfail_sense_in_i,
    input  wire       conv1_good_cmp_i,
    input  wire       conv2_good_cmp_i,
    input  wire       supply_lockout_i,
    output reg        conv1_switch_on_o,
    output reg        conv2_switch_on_o,
    output reg        chain_clock_out_o,
    output reg  [5:0] softstart_level_o,
    output reg        softstart_done_o,
    output reg        reset_n_o,
    output reg        reset_n_oe_o,
    output reg        conv1_output_good_o,
    output reg        conv1_output_good_oe_o,
    output reg        powerfail_flag_n_o,
    output reg        powerfail_flag_n_oe_o
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    wire ext_s, en1_s, en2_s, fsel_s, mr_s, pf_s, good1_s, good2_s, lock_s;
    wire mr_raw;
    // An undriven manual reset pin reads high, as an internal pull-up would.
    assign mr_raw = manual_reset_n_oe_i ? manual_reset_n_i : 1'b1;

    dcs_sync2 #(.RST_VAL(1'b0)) u_s_ext (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(ext_ref_clk_i), .q_o(ext_s));
    dcs_sync2 #(.RST_VAL(1'b0)) u_s_en1 (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(conv1_enable_i), .q_o(en1_s));
    dcs_sync2 #(.RST_VAL(1'b0)) u_s_en2 (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(conv2_enable_i), .q_o(en2_s));
    dcs_sync2 #(.RST_VAL(1'b1)) u_s_fsel (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(conv1_rate_select_i), .q_o(fsel_s));
    dcs_sync2 #(.RST_VAL(1'b0)) u_s_mr (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(mr_raw), .q_o(mr_s));
    dcs_sync2 #(.RST_VAL(1'b0)) u_s_pf (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(powerfail_sense_in_i), .q_o(pf_s));
    dcs_sync2 #(.RST_VAL(1'b0)) u_s_g1 (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(conv1_good_cmp_i), .q_o(good1_s));
    dcs_sync2 #(.RST_VAL(1'b0)) u_s_g2 (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(conv2_good_cmp_i), .q_o(good2_s));
    dcs_sync2 #(.RST_VAL(1'b1)) u_s_lock (.clk_i(clk_i), .rstn_i(rstn_i),
        .d_i(supply_lockout_i), .q_o(lock_s));

    // ----------------------------------------
    // Reference clock selection
    // ----------------------------------------
    // Internal oscillator is a divider giving one-cycle enable pulses.
    reg [7:0] osc_cnt_q;
    reg       ext_d1_q;
    reg       ext_seen_q;
    reg [7:0] ext_idle_q;
    wire      int_tick = (osc_cnt_q == OSC_DIV[7:0] - 8'h01);
    wire      ext_tick = ext_s & ~ext_d1_q;
    // A held-low external input falls back to the internal oscillator.
    wire      ref_tick = ext_seen_q ? ext_tick : int_tick;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_cnt_q  <= 8'h00;
            ext_d1_q   <= 1'b0;
            ext_seen_q <= 1'b0;
            ext_idle_q <= 8'h00;
        end else begin
            osc_cnt_q <= int_tick ? 8'h00 : osc_cnt_q + 8'h01;
            ext_d1_q  <= ext_s;
            if (ext_tick) begin
                ext_seen_q <= 1'b1;
                ext_idle_q <= 8'h00;
            end else if (ext_idle_q == 8'hff) begin
                ext_seen_q <= 1'b0;
            end else begin
                ext_idle_q <= ext_idle_q + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Phase generation
    // ----------------------------------------
    // Each reference edge advances the phase by a half switching period, so
    // a converter clock runs at half the reference. Finer phase waits a
    // quarter of the measured reference period after converter 2 turn-on
    // to place the 45 degree chain edge.
    reg       sw_clk_q;   // Divided switching clock.
    reg       half_q;     // Converter 1 slow-rate toggle.
    reg [7:0] per_cnt_q;
    reg [7:0] per_q;
    reg       chain_pend_q;
    reg [7:0] chain_dly_q;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sw_clk_q     <= 1'b0;
            half_q       <= 1'b0;
            per_cnt_q    <= 8'h00;
            per_q        <= 8'h00;
            chain_pend_q <= 1'b0;
            chain_dly_q  <= 8'h00;
        end else begin
            per_cnt_q <= ref_tick ? 8'h00 : per_cnt_q + 8'h01;
            if (ref_tick) begin
                per_q    <= per_cnt_q;
                sw_clk_q <= ~sw_clk_q;
                if (!sw_clk_q) begin
                    half_q <= ~half_q;
                end
                // Falling switching clock is converter 2 turn-on.
                if (sw_clk_q) begin
                    chain_pend_q <= 1'b1;
                    chain_dly_q  <= {2'b00, per_cnt_q[7:2]};
                end
            end else if (chain_pend_q) begin
                if (chain_dly_q == 8'h00) begin
                    chain_pend_q <= 1'b0;
                end else begin
                    chain_dly_q <= chain_dly_q - 8'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // Soft-start
    // ----------------------------------------
    reg [4:0] ss_sub_q;
    wire      run_ok = ~lock_s & (en1_s | en2_s);
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ss_sub_q          <= 5'h00;
            softstart_level_o <= 6'h00;
            softstart_done_o  <= 1'b0;
        end else if (!run_ok) begin
            ss_sub_q          <= 5'h00;
            softstart_level_o <= 6'h00;
            softstart_done_o  <= 1'b0;
        end else if (ref_tick && !softstart_done_o) begin
            // One level step per 32 oscillator cycles gives 64 steps.
            ss_sub_q <= ss_sub_q + 5'h01;
            if (ss_sub_q == 5'h1f) begin
                if (softstart_level_o == 6'h3f) begin
                    softstart_done_o <= 1'b1;
                end else begin
                    softstart_level_o <= softstart_level_o + 6'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // Switch drives and chain clock
    // ----------------------------------------
    wire rise_ev  = ref_tick & ~sw_clk_q;
    wire fall_ev  = ref_tick & sw_clk_q;
    wire c1_rate  = fsel_s | ~half_q;
    wire chain_ev = chain_pend_q & ~ref_tick & (chain_dly_q == 8'h00);

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            conv1_switch_on_o <= 1'b0;
            conv2_switch_on_o <= 1'b0;
            chain_clock_out_o <= 1'b0;
        end else begin
            // Turn-on pulses; lockout or a low enable blocks them.
            conv1_switch_on_o <= rise_ev & c1_rate & en1_s & ~lock_s;
            conv2_switch_on_o <= fall_ev & en2_s & ~lock_s;
            if (chain_ev) begin
                chain_clock_out_o <= 1'b1;
            end else if (rise_ev) begin
                chain_clock_out_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Manual reset filter and reset timeout
    // ----------------------------------------
    // Low must persist past the glitch window before it counts; this adds
    // a few cycles of latency but rejects contact bounce.
    localparam GLITCH_CYC = `DCS_GLITCH_CYC;
    reg [3:0]  mr_low_q;
    reg        mr_act_q;
    reg [23:0] rst_cnt_q;
    wire       bad = ~good1_s | ~good2_s | lock_s | ~softstart_done_o;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mr_low_q  <= 4'h0;
            mr_act_q  <= 1'b0;
            rst_cnt_q <= 24'h000000;
            reset_n_o <= 1'b0;
        end else begin
            if (mr_s) begin
                mr_low_q <= 4'h0;
                mr_act_q <= 1'b0;
            end else if (mr_low_q > GLITCH_CYC[3:0]) begin
                mr_act_q <= 1'b1;
            end else begin
                mr_low_q <= mr_low_q + 4'h1;
            end
            if (bad || mr_act_q) begin
                rst_cnt_q <= 24'h000000;
                reset_n_o <= 1'b0;
            end else if (rst_cnt_q >= RST_TIMEOUT_CYC[23:0] - 24'h000001) begin
                reset_n_o <= 1'b1;
            end else begin
                rst_cnt_q <= rst_cnt_q + 24'h000001;
            end
        end
    end

    // ----------------------------------------
    // Open-drain flags
    // ----------------------------------------
    // The comparator provides its own hysteresis; logic only follows it.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reset_n_oe_o           <= 1'b1;
            conv1_output_good_o    <= 1'b0;
            conv1_output_good_oe_o <= 1'b1;
            powerfail_flag_n_o     <= 1'b0;
            powerfail_flag_n_oe_o  <= 1'b1;
        end else begin
            reset_n_oe_o           <= bad | mr_act_q | ~reset_n_o;
            conv1_output_good_o    <= 1'b0;
            conv1_output_good_oe_o <= ~good1_s;
            powerfail_flag_n_o     <= 1'b0;
            powerfail_flag_n_oe_o  <= ~pf_s;
        end
    end
endmodule // dcs_supervisor
`default_nettype wire

/* sim/dcs_sup_properties.sv */
// Concurrent checks on the supervisor ports.
`timescale 1ns/100ps
`default_nettype none
module dcs_sup_properties #(
    parameter int RST_TIMEOUT_CYC = 200
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic conv1_enable_i,
    input wire logic manual_reset_n_i,
    input wire logic manual_reset_n_oe_i,
    input wire logic powerfail_sense_in_i,
    input wire logic conv1_good_cmp_i,
    input wire logic conv2_good_cmp_i,
    input wire logic supply_lockout_i,
    input wire logic conv1_switch_on_o,
    input wire logic conv2_switch_on_o,
    input wire logic reset_n_oe_o,
    input wire logic conv1_output_good_oe_o,
    input wire logic powerfail_flag_n_oe_o
);
    int good_cnt_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Counts how long both outputs have been good with no lockout; a release must follow the full timeout.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            good_cnt_q <= 0;
        end else if (!conv1_good_cmp_i || !conv2_good_cmp_i || supply_lockout_i) begin
            good_cnt_q <= 0;
        end else if (good_cnt_q < 1000000) begin
            good_cnt_q <= good_cnt_q + 1;
        end
    end
    lock_reset_a: assert property (supply_lockout_i [*4] |=> reset_n_oe_o)
        else $error("reset not forced under lockout");
    lock_switch_a: assert property (supply_lockout_i [*4] |=> !conv1_switch_on_o && !conv2_switch_on_o)
        else $error("switch pulse under lockout");
    bad_out_a: assert property ((!conv1_good_cmp_i || !conv2_good_cmp_i) [*4] |=> reset_n_oe_o)
        else $error("reset free with a bad output");
    pg_low_a: assert property (!conv1_good_cmp_i [*4] |=> conv1_output_good_oe_o)
        else $error("good flag free with low output");
    pg_free_a: assert property (conv1_good_cmp_i [*4] |=> !conv1_output_good_oe_o)
        else $error("good flag low with good output");
    pf_low_a: assert property (!powerfail_sense_in_i [*4] |=> powerfail_flag_n_oe_o)
        else $error("power-fail flag not driven");
    pf_free_a: assert property (powerfail_sense_in_i [*4] |=> !powerfail_flag_n_oe_o)
        else $error("power-fail flag stuck low");
    mr_hold_a: assert property ((manual_reset_n_oe_i && !manual_reset_n_i) [*8] |=> reset_n_oe_o)
        else $error("reset free during manual reset");
    release_wait_a: assert property ($fell(reset_n_oe_o) |-> good_cnt_q >= RST_TIMEOUT_CYC)
        else $error("reset released early");
    phase_apart_a: assert property (!(conv1_switch_on_o && conv2_switch_on_o))
        else $error("both switches turned on together");
    en1_gate_a: assert property (!conv1_enable_i [*4] |=> !conv1_switch_on_o)
        else $error("disabled converter switched");
    cover property ($fell(reset_n_oe_o));
    cover property (conv1_switch_on_o);
    cover property ($rose(powerfail_flag_n_oe_o));
endmodule // dcs_sup_properties
bind dcs_supervisor dcs_sup_properties #(.RST_TIMEOUT_CYC(RST_TIMEOUT_CYC)) i_dcs_sup_properties (
    .clk_i                  (clk_i),
    .rstn_i                 (rstn_i),
    .conv1_enable_i         (conv1_enable_i),
    .manual_reset_n_i       (manual_reset_n_i),
    .manual_reset_n_oe_i    (manual_reset_n_oe_i),
    .powerfail_sense_in_i   (powerfail_sense_in_i),
    .conv1_good_cmp_i       (conv1_good_cmp_i),
    .conv2_good_cmp_i       (conv2_good_cmp_i),
    .supply_lockout_i       (supply_lockout_i),
    .conv1_switch_on_o      (conv1_switch_on_o),
    .conv2_switch_on_o      (conv2_switch_on_o),
    .reset_n_oe_o           (reset_n_oe_o),
    .conv1_output_good_oe_o (conv1_output_good_oe_o),
    .powerfail_flag_n_oe_o  (powerfail_flag_n_oe_o)
);
`default_nettype wire

/* sim/dcs_far_side.sv */
// Far-side model: reference source, manual reset driver and reset pull-up.
`timescale 1ns/100ps
`default_nettype none
module dcs_far_side #(
    parameter int REF_HALF = 10
) (
    input  wire logic clk_i,
    input  wire logic ref_run_i,
    input  wire logic mr_low_i,
    input  wire logic mr_float_i,
    input  wire logic reset_n_oe_i,
    output var  logic ext_ref_clk_o = 1'h0,
    output var  logic mr_n_o,
    output var  logic mr_n_oe_o,
    output var  logic reset_line_o
);
    int ph_q = 0;
    // Reference held at ground while idle, so the internal oscillator runs.
    // It stands in for a master device's chain clock feeding this input.
    always @(posedge clk_i) begin
        ph_q <= (!ref_run_i || ph_q == REF_HALF - 1) ? 0 : ph_q + 1;
        if (!ref_run_i) begin
            ext_ref_clk_o <= 1'h0;
        end else if (ph_q == REF_HALF - 1) begin
            ext_ref_clk_o <= !ext_ref_clk_o;
        end
    end
    // A released pin keeps its data low, so only the enable says it is open.
    always_comb begin
        mr_n_oe_o = !mr_float_i;
        mr_n_o = mr_float_i ? 1'h0 : !mr_low_i;
        reset_line_o = reset_n_oe_i ? 1'h0 : 1'h1;
    end
endmodule // dcs_far_side
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the dual converter supervisor.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int TMO = 200;
    logic clk_i = 1'h0, rstn_i = 1'h0, en1 = 1'h1, en2 = 1'h1, rsel = 1'h1, sense = 1'h1;
    logic cmp1 = 1'h1, cmp2 = 1'h1, lock = 1'h0, ref_run = 1'h0, mr_low = 1'h0, mr_float = 1'h0;
    logic sw1, sw2, chain, ss_done, rst_n, rst_oe, pg, pg_oe, pf, pf_oe, ref_clk, mr_n, mr_oe, rst_line;
    logic [5:0] lvl;
    int n_mismatch = 0, check_count = 0, k, c1, c2;
    // Row: rate select, enable 1, enable 2, converter 1 pulses, converter 2 pulses.
    logic [14:0] rows [4] = '{{1'h1, 1'h1, 1'h1, 6'h10, 6'h10}, {1'h0, 1'h1, 1'h1, 6'h08, 6'h10},
                              {1'h1, 1'h0, 1'h1, 6'h00, 6'h10}, {1'h1, 1'h1, 1'h0, 6'h10, 6'h00}};
    dcs_supervisor #(.RST_TIMEOUT_CYC(TMO)) i_dcs_supervisor (.clk_i(clk_i), .rstn_i(rstn_i),
        .ext_ref_clk_i(ref_clk), .conv1_enable_i(en1), .conv2_enable_i(en2),
        .conv1_rate_select_i(rsel), .manual_reset_n_i(mr_n), .manual_reset_n_oe_i(mr_oe),
        .powerfail_sense_in_i(sense), .conv1_good_cmp_i(cmp1), .conv2_good_cmp_i(cmp2),
        .supply_lockout_i(lock), .conv1_switch_on_o(sw1), .conv2_switch_on_o(sw2),
        .chain_clock_out_o(chain), .softstart_level_o(lvl), .softstart_done_o(ss_done),
        .reset_n_o(rst_n), .reset_n_oe_o(rst_oe), .conv1_output_good_o(pg),
        .conv1_output_good_oe_o(pg_oe), .powerfail_flag_n_o(pf), .powerfail_flag_n_oe_o(pf_oe));
    dcs_far_side i_dcs_far_side (.clk_i(clk_i), .ref_run_i(ref_run), .mr_low_i(mr_low),
        .mr_float_i(mr_float), .reset_n_oe_i(rst_oe), .ext_ref_clk_o(ref_clk), .mr_n_o(mr_n),
        .mr_n_oe_o(mr_oe), .reset_line_o(rst_line));
    // The 40 ns clock.
    initial begin
        forever #20 clk_i = !clk_i;
    end
    task automatic finish_test;
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // A wait that runs out is a mismatch and ends the run at once.
    task automatic wait_rel(output int n);
        for (n = 0; n < 600 && rst_line !== 1'h1; n++) step(1);
        check("release wait", 1, n < 600);
        if (n >= 600) finish_test();
    endtask
    // Main sequence: start-up and first release, then table rows, then the awkward cases.
    initial begin
        step(10);
        check("reset held", 0, rst_line);
        rstn_i = 1'h1;
        for (k = 0; k < 20000 && ss_done !== 1'h1; k++) step(1);
        check("softstart span", 1, k >= 8192 && k <= 8700);
        check("softstart level", 6'h3f, lvl);
        wait_rel(c1);
        check("first release", 1, c1 >= TMO && c1 <= TMO + 10);
        check("reset data", 1, rst_n);
        ref_run = 1'h1;
        for (int i = 0; i < 4; i++) begin
            {rsel, en1, en2} = rows[i][14:12];
            step(60);
            c1 = 0;
            c2 = 0;
            repeat (640) begin
                c1 += (sw1 === 1'h1);
                c2 += (sw2 === 1'h1);
                step(1);
            end
            check("conv1 pulses", rows[i][11:6], c1);
            check("conv2 pulses", rows[i][5:0], c2);
        end
        // Converter 2 enable is set once from the converter 1 good pin state, as a sequencer would at start.
        rsel = 1'h1;
        en1 = 1'h1;
        en2 = !pg_oe;
        step(5);
        for (k = 0; k < 60 && sw2 !== 1'h1; k++) step(1);
        check("conv2 seen", 1, k < 60);
        for (k = 0; k < 20 && chain !== 1'h1; k++) step(1);
        check("chain lag", 1, k >= 4 && k <= 6);
        sense = 1'h0;
        step(5);
        check("pf driven", 1, pf_oe);
        check("pf data", 0, pf);
        sense = 1'h1;
        step(5);
        check("pf free", 0, pf_oe);
        cmp1 = 1'h0;
        step(5);
        check("pg driven", 1, pg_oe);
        check("pg data", 0, pg);
        check("reset on out1", 0, rst_line);
        cmp1 = 1'h1;
        wait_rel(k);
        check("release out1", 1, k >= TMO && k <= TMO + 10);
        check("pg free", 0, pg_oe);
        cmp2 = 1'h0;
        step(5);
        check("reset on out2", 0, rst_line);
        cmp2 = 1'h1;
        wait_rel(k);
        check("release out2", 1, k >= TMO && k <= TMO + 10);
        mr_low = 1'h1;
        step(2);
        mr_low = 1'h0;
        step(30);
        check("glitch ignored", 1, rst_line);
        mr_low = 1'h1;
        step(20);
        check("manual reset", 0, rst_line);
        mr_low = 1'h0;
        wait_rel(k);
        check("manual timeout", 1, k >= TMO && k <= TMO + 10);
        mr_float = 1'h1;
        step(30);
        check("open manual", 1, rst_line);
        lock = 1'h1;
        step(5);
        c1 = 0;
        repeat (60) begin
            c1 += (sw1 === 1'h1) + (sw2 === 1'h1);
            step(1);
        end
        check("lockout reset", 0, rst_line);
        check("lockout pulses", 0, c1);
        // Mid-run reset: outputs go to their reset levels, lockout keeps reset after release.
        rstn_i = 1'h0;
        step(2);
        check("reset outputs", 5'h03, {sw1, sw2, chain, pg_oe, pf_oe});
        check("reset line in reset", 0, rst_line);
        rstn_i = 1'h1;
        step(2);
        check("reset after release", 0, rst_line);
        finish_test();
    end
endmodule // tb
`default_nettype wire
